// *** design/timer_b_map.svh ***
// Register offsets, field positions and reset values of the 16-bit timer.
// Assumes byte-wide register access at the printed offsets.
`ifndef TIMER_B_MAP_SVH
`define TIMER_B_MAP_SVH

`define TB_OFF_CTRL_A 4'h0
`define TB_OFF_CTRL_B 4'h1
`define TB_OFF_EVENT_CTRL 4'h4
`define TB_OFF_INT_CTRL 4'h5
`define TB_OFF_INT_FLAGS 4'h6
`define TB_OFF_RUN_STATUS 4'h7
`define TB_OFF_DEBUG_CTRL 4'h8
`define TB_OFF_LATCH 4'h9
`define TB_OFF_COUNT_LO 4'hA
`define TB_OFF_COUNT_HI 4'hB
`define TB_OFF_COMPARE_LO 4'hC
`define TB_OFF_COMPARE_HI 4'hD

`define TB_BIT_ENABLE 0
`define TB_MODE_MSB 2
`define TB_MODE_LSB 0
`define TB_BIT_EDGE 4
`define TB_BIT_EVENT_EN 0
`define TB_BIT_INT_EN 0
`define TB_BIT_FLAG 0
`define TB_BIT_RUN 0
`define TB_BIT_HALT_CONTINUE 0

`define TB_COUNT_RST 16'h0000
`define TB_COMPARE_RST 16'h0000
`define TB_BYTE_RST 8'h00

`endif

// *** design/timer_b_pkg.sv ***
// Types shared by the timer design files.
// Assumes nothing beyond a SystemVerilog compiler.
package timer_b_pkg;

  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_EVENT_FLAG_BIT_EVENT = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PULSE_WIDTH = 3'h4,
    MODE_FREQ_PW = 3'h5,
    MODE_SINGLE_SHOT = 3'h6,
    MODE_PWM8 = 3'h7
  } timer_mode_e;

  typedef enum logic [1:0] {
    FPW_WAIT_FIRST = 2'h0,
    FPW_WAIT_OPP = 2'h1,
    FPW_WAIT_SECOND = 2'h3
  } fpw_state_e;

endpackage

// *** design/event_edge_sync.sv ***
// Three-stage synchroniser with edge pulses for the event input.
// Assumes the input comes from outside the core clock domain.
`timescale 1ns/100ps
module event_edge_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic [2:0] sync_q;
  logic stable_q;
  logic rise_q;
  logic fall_q;
  wire agree = (sync_q[1] == sync_q[2]);
  wire change = agree && (sync_q[2] != stable_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h0;
      stable_q <= 1'h0;
      rise_q <= 1'h0;
      fall_q <= 1'h0;
    end else begin
      sync_q <= {sync_q[1:0], async_in};
      if (change) begin
        stable_q <= sync_q[2];
      end
      rise_q <= change && sync_q[2];
      fall_q <= change && !sync_q[2];
    end
  end

  assign rise = rise_q;
  assign fall = fall_q;
endmodule // event_edge_sync

// *** design/timer_b_instance.sv ***
// 16-bit timer with mode-dependent flag, byte latch and debug halt.
// Assumes byte register access from processor or debug interface on core_clk.
`timescale 1ns/100ps
`include "timer_b_map.svh"
module timer_b_instance (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic event_in,
  input wire logic debug_break,
  output logic irq
);
  import timer_b_pkg::*;

  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic enable_q;
  timer_mode_e mode_q;
  logic edge_q;
  logic event_en_q;
  logic int_en_q;
  logic flag_q;
  logic flag_d;
  logic halt_continue_q;
  logic [7:0] latch_q;
  logic [15:0] count_q;
  logic [15:0] compare_q;
  logic run_q;
  fpw_state_e fpw_q;
  logic [7:0] rdata_q;
  logic irq_q;

  // Event edges
  logic ev_rise;
  logic ev_fall;
  event_edge_sync u_event_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(event_in),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  // Address decode
  wire wr_ctrl_a = reg_wr && (reg_addr == `TB_OFF_CTRL_A);
  wire wr_ctrl_b = reg_wr && (reg_addr == `TB_OFF_CTRL_B);
  wire wr_ev_ctrl = reg_wr && (reg_addr == `TB_OFF_EVENT_CTRL);
  wire wr_int_ctrl = reg_wr && (reg_addr == `TB_OFF_INT_CTRL);
  wire wr_flags = reg_wr && (reg_addr == `TB_OFF_INT_FLAGS);
  wire wr_debug = reg_wr && (reg_addr == `TB_OFF_DEBUG_CTRL);
  wire wr_latch = reg_wr && (reg_addr == `TB_OFF_LATCH);
  wire wr_count_lo = reg_wr && (reg_addr == `TB_OFF_COUNT_LO);
  wire wr_count_hi = reg_wr && (reg_addr == `TB_OFF_COUNT_HI);
  wire wr_cmp_lo = reg_wr && (reg_addr == `TB_OFF_COMPARE_LO);
  wire wr_cmp_hi = reg_wr && (reg_addr == `TB_OFF_COMPARE_HI);
  wire rd_count_lo = reg_rd && (reg_addr == `TB_OFF_COUNT_LO);
  wire rd_cmp_lo = reg_rd && (reg_addr == `TB_OFF_COMPARE_LO);

  wire pwm_mode = (mode_q == MODE_PWM8);
  wire capture_mode = (mode_q == MODE_EVENT_FLAG_BIT_EVENT) || (mode_q == MODE_FREQ) ||
                      (mode_q == MODE_PULSE_WIDTH) || (mode_q == MODE_FREQ_PW);

  // Debug halt gating
  wire halted = debug_break && !halt_continue_q;
  wire active = enable_q && !halted;
  wire ev_ok = active && event_en_q;
  wire sel_edge = ev_ok && (edge_q ? ev_fall : ev_rise);
  wire opp_edge = ev_ok && (edge_q ? ev_rise : ev_fall);
  wire ss_start = ev_ok && (edge_q ? (ev_rise || ev_fall) : ev_rise);
  wire tick = active && run_q;
  wire top_hit = (count_q == compare_q);
  wire pwm_hit = (count_q[7:0] == compare_q[7:0]);
  wire pwm_wrap = (count_q[7:0] == compare_q[15:8]);

  // Mode behaviour
  logic [15:0] count_n;
  logic capture;
  logic flag_set;
  logic run_n;
  fpw_state_e fpw_n;
  always_comb begin
    count_n = tick ? count_q + 16'h0001 : count_q;
    capture = 1'h0;
    flag_set = 1'h0;
    run_n = run_q;
    fpw_n = fpw_q;
    unique case (mode_q)
      MODE_PERIODIC: begin
        run_n = enable_q;
        if (tick && top_hit) begin
          count_n = 16'h0000;
          flag_set = 1'h1;
        end
      end
      MODE_TIMEOUT: begin
        if (tick && top_hit) begin
          count_n = count_q;
          run_n = 1'h0;
          flag_set = 1'h1;
        end
        if (sel_edge) begin
          count_n = 16'h0000;
          run_n = 1'h1;
        end else if (opp_edge) begin
          run_n = 1'h0;
        end
      end
      MODE_EVENT_FLAG_BIT_EVENT: begin
        run_n = enable_q;
        if (sel_edge) begin
          capture = 1'h1;
          flag_set = 1'h1;
        end
      end
      MODE_FREQ: begin
        run_n = enable_q;
        if (sel_edge) begin
          capture = 1'h1;
          count_n = 16'h0000;
          flag_set = 1'h1;
        end
      end
      MODE_PULSE_WIDTH: begin
        run_n = enable_q;
        if (sel_edge) begin
          count_n = 16'h0000;
        end
        if (opp_edge) begin
          capture = 1'h1;
          flag_set = 1'h1;
        end
      end
      MODE_FREQ_PW: begin
        unique case (fpw_q)
          FPW_WAIT_FIRST: begin
            if (sel_edge) begin
              count_n = 16'h0000;
              run_n = 1'h1;
              fpw_n = FPW_WAIT_OPP;
            end
          end
          FPW_WAIT_OPP: begin
            if (opp_edge) begin
              capture = 1'h1;
              fpw_n = FPW_WAIT_SECOND;
            end
          end
          FPW_WAIT_SECOND: begin
            if (sel_edge) begin
              count_n = count_q;
              run_n = 1'h0;
              flag_set = 1'h1;
              fpw_n = FPW_WAIT_FIRST;
            end
          end
          default: begin
            fpw_n = FPW_WAIT_FIRST;
          end
        endcase
      end
      MODE_SINGLE_SHOT: begin
        if (tick && top_hit) begin
          count_n = count_q;
          run_n = 1'h0;
          flag_set = 1'h1;
        end else if (ss_start && !run_q) begin
          count_n = 16'h0000;
          run_n = 1'h1;
        end
      end
      MODE_PWM8: begin
        run_n = enable_q;
        if (tick) begin
          count_n = pwm_wrap ? 16'h0000 : {8'h00, count_q[7:0] + 8'h01};
          flag_set = pwm_hit;
        end
      end
    endcase
    if (!enable_q) begin
      run_n = 1'h0;
    end
    if (mode_q != MODE_FREQ_PW) begin
      fpw_n = FPW_WAIT_FIRST;
    end
  end

  // Flag: set beats clear
  wire read_clear = rd_cmp_lo && capture_mode;
  wire w1c_clear = wr_flags && reg_wdata[`TB_BIT_FLAG];
  assign flag_d = flag_set || (flag_q && !(w1c_clear || read_clear));

  // Byte latch next value
  wire [7:0] latch_n = wr_latch ? reg_wdata :
                       wr_count_hi ? reg_wdata :
                       (wr_cmp_hi && !pwm_mode) ? reg_wdata :
                       rd_count_lo ? count_q[15:8] :
                       (rd_cmp_lo && !pwm_mode) ? compare_q[15:8] : latch_q;

  // Counter and compare next values
  wire [15:0] count_d = wr_count_lo ? {latch_q, reg_wdata} : count_n;
  wire [15:0] compare_d = wr_cmp_lo ? (pwm_mode ? {compare_q[15:8], reg_wdata} : {latch_q, reg_wdata}) :
                          (wr_cmp_hi && pwm_mode) ? {reg_wdata, compare_q[7:0]} :
                          capture ? count_q : compare_q;

  // Read mux
  wire [7:0] rd_mux =
    (reg_addr == `TB_OFF_CTRL_A) ? {7'h00, enable_q} :
    (reg_addr == `TB_OFF_CTRL_B) ? {5'h00, mode_q} :
    (reg_addr == `TB_OFF_EVENT_CTRL) ? {3'h0, edge_q, 3'h0, event_en_q} :
    (reg_addr == `TB_OFF_INT_CTRL) ? {7'h00, int_en_q} :
    (reg_addr == `TB_OFF_INT_FLAGS) ? {7'h00, flag_q} :
    (reg_addr == `TB_OFF_RUN_STATUS) ? {7'h00, run_q} :
    (reg_addr == `TB_OFF_DEBUG_CTRL) ? {7'h00, halt_continue_q} :
    (reg_addr == `TB_OFF_LATCH) ? latch_q :
    (reg_addr == `TB_OFF_COUNT_LO) ? count_q[7:0] :
    (reg_addr == `TB_OFF_COUNT_HI) ? latch_q :
    (reg_addr == `TB_OFF_COMPARE_LO) ? compare_q[7:0] :
    (reg_addr == `TB_OFF_COMPARE_HI) ? (pwm_mode ? compare_q[15:8] : latch_q) : 8'h00;

  // Control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'h0;
      mode_q <= MODE_PERIODIC;
      edge_q <= 1'h0;
      event_en_q <= 1'h0;
      int_en_q <= 1'h0;
      halt_continue_q <= 1'h0;
    end else begin
      if (wr_ctrl_a) enable_q <= reg_wdata[`TB_BIT_ENABLE];
      if (wr_ctrl_b) mode_q <= timer_mode_e'(reg_wdata[`TB_MODE_MSB:`TB_MODE_LSB]);
      if (wr_ev_ctrl) edge_q <= reg_wdata[`TB_BIT_EDGE];
      if (wr_ev_ctrl) event_en_q <= reg_wdata[`TB_BIT_EVENT_EN];
      if (wr_int_ctrl) int_en_q <= reg_wdata[`TB_BIT_INT_EN];
      if (wr_debug) halt_continue_q <= reg_wdata[`TB_BIT_HALT_CONTINUE];
    end
  end

  // Timer state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TB_COUNT_RST;
      compare_q <= `TB_COMPARE_RST;
      latch_q <= `TB_BYTE_RST;
      flag_q <= 1'h0;
      run_q <= 1'h0;
      fpw_q <= FPW_WAIT_FIRST;
    end else begin
      count_q <= count_d;
      compare_q <= compare_d;
      latch_q <= latch_n;
      flag_q <= flag_d;
      run_q <= run_n;
      fpw_q <= fpw_n;
    end
  end

  // Output registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      irq_q <= 1'h0;
    end else begin
      if (reg_rd) rdata_q <= rd_mux;
      irq_q <= flag_d && (wr_int_ctrl ? reg_wdata[`TB_BIT_INT_EN] : int_en_q);
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence pw_armed_s;
    (mode_q == MODE_PULSE_WIDTH) && sel_edge && !wr_count_lo;
  endsequence
  sequence pw_done_s;
    (mode_q == MODE_PULSE_WIDTH) && opp_edge && !wr_cmp_lo && !wr_cmp_hi;
  endsequence
  sequence fpw_second_s;
    (mode_q == MODE_FREQ_PW) && (fpw_q == FPW_WAIT_SECOND) && sel_edge;
  endsequence

  flag_clear_a : assert property (
    (w1c_clear || read_clear) && !flag_set |=> !flag_q)
    else $error("flag not cleared");
  periodic_top_a : assert property (
    (mode_q == MODE_PERIODIC) && tick && top_hit && !wr_count_lo |=> flag_q && (count_q == 16'h0000))
    else $error("periodic top not handled");
  capture_event_a : assert property (
    (mode_q == MODE_EVENT_FLAG_BIT_EVENT) && sel_edge && !wr_cmp_lo && !wr_cmp_hi
      |=> flag_q && (compare_q == $past(count_q)))
    else $error("capture on event wrong");
  freq_restart_a : assert property (
    (mode_q == MODE_FREQ) && sel_edge && !wr_count_lo && !wr_cmp_lo
      |=> flag_q && (count_q == 16'h0000) && (compare_q == $past(count_q)))
    else $error("frequency capture wrong");
  pulse_restart_a : assert property (
    pw_armed_s |=> (count_q == 16'h0000))
    else $error("pulse width restart wrong");
  pulse_width_a : assert property (
    pw_done_s |=> flag_q && (compare_q == $past(count_q)))
    else $error("pulse width capture wrong");
  combined_stop_a : assert property (
    fpw_second_s |=> !run_q && flag_q)
    else $error("combined mode stop wrong");
  single_shot_a : assert property (
    (mode_q == MODE_SINGLE_SHOT) && tick && top_hit && !wr_count_lo
      |=> flag_q && !run_q && (count_q == $past(count_q)))
    else $error("single shot top not handled");
  pwm_flag_a : assert property (
    pwm_mode && tick && pwm_hit |=> flag_q)
    else $error("pwm flag missing");
  run_status_a : assert property (
    reg_rd && (reg_addr == `TB_OFF_RUN_STATUS) |=> reg_rdata == {7'h00, $past(run_q)})
    else $error("run status read wrong");
  debug_halt_a : assert property (
    halted && !wr_count_lo |=> count_q == $past(count_q))
    else $error("counter moved while halted");
  latch_copy_a : assert property (
    rd_count_lo && !reg_wr |=> latch_q == $past(count_q[15:8]))
    else $error("latch not loaded on low read");
  write_priority_a : assert property (
    wr_count_lo |=> count_q == {$past(latch_q), $past(reg_wdata)})
    else $error("counter write lost");
  irq_follow_a : assert property (
    irq_q == (flag_q && int_en_q))
    else $error("irq mismatch");
endmodule // timer_b_instance

// *** tb/timer_b_instance_tb_top.sv ***
// Self-checking bench for the 16-bit timer register block.
// Assumes the design package, map header and modules are compiled first.
`timescale 1ns/100ps
module timer_b_instance_tb_top;
  import timer_b_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic event_in = 1'b0;
  logic debug_break = 1'b0;
  logic irq;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h40CD;
  logic [15:0] a, b, v;
  logic [7:0] d;
  logic [3:0] offs [7] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};

  timer_b_instance DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_in(event_in),
    .debug_break(debug_break), .irq(irq));

  always #12.5 core_clk = ~core_clk;

  function automatic logic [15:0] rnd16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // Event control word: edge polarity plus event input enable
  function automatic logic [7:0] evc(input logic e);
    return {3'h0, e, 4'h1};
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] g);
    num_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      failures++;
      $display("[FAIL] %s expected %h..%h got %h", n, lo, hi, g);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 dt = reg_rdata;
  endtask

  task automatic w16(input logic [3:0] ad, input logic [15:0] x);
    wr(ad + 4'h1, x[15:8]);
    wr(ad, x[7:0]);
  endtask

  task automatic r16(input logic [3:0] ad, output logic [15:0] x);
    logic [7:0] lo, hi;
    rd(ad, lo);
    rd(ad + 4'h1, hi);
    x = {hi, lo};
  endtask

  task automatic chk_flag(input logic e);
    logic [7:0] f;
    rd(4'h6, f);
    chk("flag", {15'h0, e}, {15'h0, f[0]});
  endtask

  task automatic mode(input timer_mode_e m, input logic e);
    wr(4'h1, {5'h00, m});
    wr(4'h4, evc(e));
    wr(4'h6, 8'h01);
  endtask

  task automatic ev(input logic lvl);
    @(posedge core_clk);
    event_in <= lvl;
    repeat (10) @(posedge core_clk);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    failures++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    wr(4'h7, 8'hFF);
    rd(4'h7, d);
    chk("run read-only", 16'h0000, {8'h00, d});
    repeat (4) begin
      v = rnd16();
      wr(4'h9, v[7:0]);
      rd(4'h9, d);
      chk("latch", {8'h00, v[7:0]}, {8'h00, d});
      v = rnd16();
      w16(4'hA, v);
      r16(4'hA, a);
      chk("count", v, a);
      v = rnd16();
      w16(4'hC, v);
      r16(4'hC, a);
      chk("compare", v, a);
    end
    // Periodic: top from compare, flag, irq, mask
    mode(MODE_PERIODIC, 1'b0);
    w16(4'hC, 16'h0010 + {12'h0, v[3:0]});
    w16(4'hA, 16'h0000);
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
    for (int i = 0; i < 80 && irq !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("irq", 16'h0001, {15'h0, irq});
    rd(4'h7, d);
    chk("run", 16'h0001, {15'h0, d[0]});
    wr(4'h6, 8'h01);
    chk_flag(1'b0);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    wr(4'h5, 8'h00);
    repeat (40) @(posedge core_clk);
    chk_flag(1'b1);
    chk("irq masked", 16'h0000, {15'h0, irq});
    // Debug halt freezes count and drops events
    w16(4'hC, 16'hFFFF);
    w16(4'hA, 16'h1000);
    wr(4'h8, 8'h00);
    @(posedge core_clk);
    debug_break <= 1'b1;
    r16(4'hA, a);
    repeat (5) @(posedge core_clk);
    r16(4'hA, b);
    chk("halted count", a, b);
    mode(MODE_EVENT_FLAG_BIT_EVENT, 1'b0);
    ev(1'b1);
    chk_flag(1'b0);
    ev(1'b0);
    wr(4'h8, 8'h01);
    r16(4'hA, a);
    r16(4'hA, b);
    chk_rng("debug run", a + 16'd1, a + 16'd20, b);
    @(posedge core_clk);
    debug_break <= 1'b0;
    // Capture on event
    r16(4'hA, a);
    ev(1'b1);
    chk_flag(1'b1);
    r16(4'hC, b);
    chk_rng("capture", a, a + 16'd40, b);
    chk_flag(1'b0);
    ev(1'b0);
    chk_flag(1'b0);
    // Frequency measurement
    mode(MODE_FREQ, 1'b0);
    w16(4'hA, 16'h8000);
    ev(1'b1);
    chk_flag(1'b1);
    r16(4'hA, a);
    chk_rng("restart", 16'h0000, 16'h0040, a);
    r16(4'hC, b);
    chk_rng("freq capture", 16'h8000, 16'h8040, b);
    ev(1'b0);
    // Pulse width
    mode(MODE_PULSE_WIDTH, 1'b0);
    w16(4'hA, 16'h8000);
    ev(1'b1);
    chk_flag(1'b0);
    ev(1'b0);
    chk_flag(1'b1);
    r16(4'hC, b);
    chk_rng("width", 16'h0001, 16'h0030, b);
    // Frequency and pulse width
    mode(MODE_FREQ_PW, 1'b0);
    ev(1'b1);
    ev(1'b0);
    chk_flag(1'b0);
    ev(1'b1);
    chk_flag(1'b1);
    rd(4'h7, d);
    chk("stopped", 16'h0000, {15'h0, d[0]});
    ev(1'b0);
    // Single shot and timeout, top 0x20
    mode(MODE_SINGLE_SHOT, 1'b0);
    w16(4'hC, 16'h0020);
    ev(1'b1);
    repeat (50) @(posedge core_clk);
    chk_flag(1'b1);
    r16(4'hA, a);
    chk_rng("single stop", 16'h0020, 16'h0021, a);
    ev(1'b0);
    mode(MODE_TIMEOUT, 1'b0);
    ev(1'b1);
    repeat (50) @(posedge core_clk);
    chk_flag(1'b1);
    ev(1'b0);
    // 8-bit PWM with independent compare bytes
    w16(4'hA, 16'h0000);
    wr(4'h0, 8'h00);
    mode(MODE_PWM8, 1'b0);
    wr(4'h0, 8'h01);
    wr(4'h9, 8'h77);
    wr(4'hC, 8'h05);
    wr(4'hD, 8'h20);
    rd(4'hD, d);
    chk("pwm high", 16'h0020, {8'h00, d});
    rd(4'hC, d);
    chk("pwm low", 16'h0005, {8'h00, d});
    rd(4'h9, d);
    chk("latch kept", 16'h0077, {8'h00, d});
    wr(4'h6, 8'h01);
    repeat (80) @(posedge core_clk);
    chk_flag(1'b1);
    // Write while counting wins
    mode(MODE_PERIODIC, 1'b0);
    w16(4'hC, 16'hFFFF);
    v = rnd16() & 16'h7FFF;
    w16(4'hA, v);
    r16(4'hA, a);
    chk_rng("count write", v, v + 16'd8, a);
    test_done();
  end
endmodule // timer_b_instance_tb_top
